// ===== dhs_pkg.sv
// Package for the proximity-dog homing sequencer: map, fields, reset values and state types
package dhs_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 4;
	localparam int SPD_W = 16;

	// Register word offsets
	localparam logic [3:0] OFS_CFG = 4'h0;
	localparam logic [3:0] OFS_HOME_SPD = 4'h1;
	localparam logic [3:0] OFS_CREEP_SPD = 4'h2;
	localparam logic [3:0] OFS_SHIFT = 4'h3;
	localparam logic [3:0] OFS_POSTDOG = 4'h4;
	localparam logic [3:0] OFS_ACC = 4'h5;
	localparam logic [3:0] OFS_HOME_POS = 4'h6;
	localparam logic [3:0] OFS_STATUS = 4'h7;
	localparam logic [3:0] OFS_CUR_POS = 4'h8;

	// Homing configuration field positions
	localparam int CFG_METHOD_LSB = 0;
	localparam int CFG_DIR_BIT = 4;
	localparam int CFG_POL_BIT = 5;

	// Homing method codes
	localparam logic [3:0] METHOD_REAR = 4'h5;
	localparam logic [3:0] METHOD_COUNT = 4'h6;

	// Reset values
	localparam logic [7:0] RST_CFG = 8'h05;
	localparam logic [15:0] RST_HOME_SPD = 16'h0064;
	localparam logic [15:0] RST_CREEP_SPD = 16'h000A;
	localparam logic [31:0] RST_SHIFT = 32'h0000_0000;
	localparam logic [31:0] RST_POSTDOG = 32'h0000_0000;
	localparam logic [15:0] RST_ACC = 16'h0000;
	localparam logic [31:0] RST_HOME_POS = 32'h0000_0000;

	// Motion tick: one position update per tick
	localparam int CLK_NS = 40;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FAST = 3'b001,
		ST_CREEP = 3'b010,
		ST_FINAL = 3'b011
	} dhs_state_e;

	typedef struct packed {
		logic [7:0] cfg;
		logic [15:0] home_spd;
		logic [15:0] creep_spd;
		logic [31:0] shift;
		logic [31:0] postdog;
		logic [15:0] acc;
		logic [31:0] home_pos;
	} dhs_regs_s;

	typedef struct packed {
		logic auto_manual_select;
		logic [4:0] table_select;
		logic register_posspeed_select;
		logic proximity_dog_input;
		logic start;
	} dhs_cmd_s;
endpackage

// ===== dhs_ramp.sv
// Speed ramp generator: steps the speed toward a target at the configured rate
`timescale 1ns/1ps
module dhs_ramp #(
	parameter int SPD_W = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_tick,
	input wire logic i_stop,
	input wire logic [SPD_W-1:0] i_target,
	input wire logic [15:0] i_acc_ticks,
	output logic [SPD_W-1:0] o_speed
);
	import dhs_pkg::*;

	typedef struct packed {
		logic [SPD_W-1:0] spd;
		logic [15:0] cnt;
	} dhs_ramp_s;

	dhs_ramp_s s_r;
	dhs_ramp_s s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (i_stop) begin
			s_nxt.spd = '0;
			s_nxt.cnt = '0;
		end else if (i_tick) begin
			// One speed step per acc_ticks+1 motion ticks, both ways alike
			if (s_r.cnt >= i_acc_ticks) begin
				s_nxt.cnt = '0;
				if (s_r.spd < i_target) begin
					s_nxt.spd = s_r.spd + 1'b1;
				end else if (s_r.spd > i_target) begin
					s_nxt.spd = s_r.spd - 1'b1;
				end
			end else begin
				s_nxt.cnt = s_r.cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_speed = s_r.spd;

	a_ramp_step: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!i_stop && !$past(i_stop) |-> (s_r.spd == $past(s_r.spd)) || (s_r.spd == $past(s_r.spd) + 1'b1)
		|| (s_r.spd == $past(s_r.spd) - 1'b1))
		else $error("speed jumped by more than one step");
endmodule

// ===== dhs_homing.sv
// Proximity-dog homing sequencer top: register port, start gating, dog edges, distance count
//
// Function
// - Method code 5 runs the rear-end reference dog homing.
// - Method code 6 runs the count-type front-end reference dog homing.
// - Direction and dog polarity come from separate fields of the config register.
// - Move at homing speed until the dog is detected.
// - After the dog is detected, decelerate to creep speed and continue.
// - Deceleration starts at the active edge of the dog front end.
// - Rear method: home after post-dog plus shift distance from dog rear end.
// - Count method: home after post-dog plus shift distance from deceleration start.
// - No encoder index pulse is used for the home position.
// - Homing ramps use the first point-table acceleration/deceleration time constant; the code takes it from the ACC register instead.
// - On completion the current position loads the configured home position value.
// - Sampled dog input gives a speed-dependent home error; count method shifts with speed.
`timescale 1ns/1ps
module dhs_homing (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [dhs_pkg::ADDR_W-1:0] i_addr,
	input wire logic [dhs_pkg::DATA_W-1:0] i_wr_data,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	output logic [dhs_pkg::DATA_W-1:0] o_rd_data,
	input wire logic i_auto_manual_select,
	input wire logic i_table_select_1,
	input wire logic i_table_select_2,
	input wire logic i_table_select_3,
	input wire logic i_table_select_4,
	input wire logic i_table_select_5,
	input wire logic i_register_posspeed_select,
	input wire logic i_proximity_dog_input,
	input wire logic i_start,
	output logic [dhs_pkg::SPD_W-1:0] o_speed,
	output logic o_dir,
	output logic o_busy,
	output logic o_done,
	output logic [dhs_pkg::DATA_W-1:0] o_cur_pos
);
	import dhs_pkg::*;

	typedef struct packed {
		dhs_regs_s regs;
		dhs_state_e st;
		logic dog_q;
		logic [7:0] tick_cnt;
		logic tick;
		logic [31:0] travelled;
		logic [31:0] cur_pos;
		logic [SPD_W-1:0] speed;
		logic dir;
		logic busy;
		logic done;
		logic [31:0] rd_data;
	} dhs_top_s;

	dhs_top_s s_r;
	dhs_top_s s_nxt;
	dhs_cmd_s cmd;
	logic [SPD_W-1:0] ramp_spd;
	logic [SPD_W-1:0] target_spd;
	logic ramp_stop;
	logic [3:0] method;
	logic dog_act;
	logic dog_front;
	logic dog_rear;
	logic mode_ok;
	logic [32:0] goal;
	logic [32:0] reach;

	assign cmd = '{auto_manual_select: i_auto_manual_select,
		table_select: {i_table_select_5, i_table_select_4, i_table_select_3, i_table_select_2, i_table_select_1},
		register_posspeed_select: i_register_posspeed_select,
		proximity_dog_input: i_proximity_dog_input,
		start: i_start};

	assign method = s_r.regs.cfg[CFG_METHOD_LSB +: 4];
	// Dog is sampled once per clock, so its edges are only as exact as the travel per sample
	assign dog_act = cmd.proximity_dog_input ^ s_r.regs.cfg[CFG_POL_BIT];
	assign dog_front = dog_act && !s_r.dog_q;
	assign dog_rear = !dog_act && s_r.dog_q;
	assign mode_ok = cmd.auto_manual_select && (cmd.table_select == 5'h00)
		&& !cmd.register_posspeed_select
		&& ((method == METHOD_REAR) || (method == METHOD_COUNT));
	assign goal = {1'b0, s_r.regs.postdog} + {1'b0, s_r.regs.shift};
	assign reach = {1'b0, s_r.travelled} + {17'h0_0000, ramp_spd};
	assign target_spd = (s_r.st == ST_FAST) ? s_r.regs.home_spd : s_r.regs.creep_spd;
	assign ramp_stop = (s_r.st == ST_IDLE);

	dhs_ramp #(
		.SPD_W(SPD_W)
	) u_ramp (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_tick(s_r.tick),
		.i_stop(ramp_stop),
		.i_target(target_spd),
		.i_acc_ticks(s_r.regs.acc),
		.o_speed(ramp_spd)
	);

	always_comb begin
		s_nxt = s_r;
		s_nxt.dog_q = dog_act;
		s_nxt.speed = ramp_spd;
		s_nxt.done = 1'b0;
		s_nxt.rd_data = '0;

		// Motion tick divider
		s_nxt.tick = 1'b0;
		if (s_r.tick_cnt == TICK_LAST) begin
			s_nxt.tick_cnt = '0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.tick_cnt = s_r.tick_cnt + 8'h01;
		end

		// Register writes; config is frozen while homing so a run sees one setting
		if (i_wr_en && !s_r.busy) begin
			case (i_addr)
				OFS_CFG: s_nxt.regs.cfg = i_wr_data[7:0];
				OFS_HOME_SPD: s_nxt.regs.home_spd = i_wr_data[15:0];
				OFS_CREEP_SPD: s_nxt.regs.creep_spd = i_wr_data[15:0];
				OFS_SHIFT: s_nxt.regs.shift = i_wr_data;
				OFS_POSTDOG: s_nxt.regs.postdog = i_wr_data;
				OFS_ACC: s_nxt.regs.acc = i_wr_data[15:0];
				OFS_HOME_POS: s_nxt.regs.home_pos = i_wr_data;
				default: begin
				end
			endcase
		end

		if (i_rd_en) begin
			case (i_addr)
				OFS_CFG: s_nxt.rd_data = {24'h00_0000, s_r.regs.cfg};
				OFS_HOME_SPD: s_nxt.rd_data = {16'h0000, s_r.regs.home_spd};
				OFS_CREEP_SPD: s_nxt.rd_data = {16'h0000, s_r.regs.creep_spd};
				OFS_SHIFT: s_nxt.rd_data = s_r.regs.shift;
				OFS_POSTDOG: s_nxt.rd_data = s_r.regs.postdog;
				OFS_ACC: s_nxt.rd_data = {16'h0000, s_r.regs.acc};
				OFS_HOME_POS: s_nxt.rd_data = s_r.regs.home_pos;
				OFS_STATUS: s_nxt.rd_data = {26'h000_0000, dog_act, s_r.st, s_r.done, s_r.busy};
				OFS_CUR_POS: s_nxt.rd_data = s_r.cur_pos;
				default: s_nxt.rd_data = '0;
			endcase
		end

		// Position follows the commanded speed every motion tick
		if (s_r.tick && s_r.busy) begin
			s_nxt.cur_pos = s_r.dir ? (s_r.cur_pos - {16'h0000, ramp_spd}) : (s_r.cur_pos + {16'h0000, ramp_spd});
			s_nxt.travelled = reach[31:0];
		end

		// No index pulse input exists; home is set purely by dog edges and distance
		case (s_r.st)
			ST_IDLE: begin
				if (cmd.start && mode_ok) begin
					s_nxt.st = ST_FAST;
					s_nxt.busy = 1'b1;
					s_nxt.dir = s_r.regs.cfg[CFG_DIR_BIT];
					s_nxt.travelled = '0;
				end
			end
			ST_FAST: begin
				if (dog_front) begin
					s_nxt.travelled = '0;
					s_nxt.st = (method == METHOD_COUNT) ? ST_FINAL : ST_CREEP;
				end
			end
			ST_CREEP: begin
				if (dog_rear) begin
					s_nxt.travelled = '0;
					s_nxt.st = ST_FINAL;
				end
			end
			ST_FINAL: begin
				// Stop is abrupt at the goal; the ramp only shapes speed changes on the way
				if (s_r.tick && (reach >= goal)) begin
					s_nxt.st = ST_IDLE;
					s_nxt.busy = 1'b0;
					s_nxt.done = 1'b1;
					s_nxt.cur_pos = s_r.regs.home_pos;
					s_nxt.travelled = '0;
				end
			end
			default: begin
				s_nxt.st = ST_IDLE;
				s_nxt.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			s_r <= '0;
			s_r.regs <= '{cfg: RST_CFG, home_spd: RST_HOME_SPD, creep_spd: RST_CREEP_SPD, shift: RST_SHIFT,
				postdog: RST_POSTDOG, acc: RST_ACC, home_pos: RST_HOME_POS};
			s_r.st <= ST_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_rd_data = s_r.rd_data;
	assign o_speed = s_r.speed;
	assign o_dir = s_r.dir;
	assign o_busy = s_r.busy;
	assign o_done = s_r.done;
	assign o_cur_pos = s_r.cur_pos;

	a_mode_select_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_r.st == ST_IDLE) && i_start && (!i_auto_manual_select || (cmd.table_select != 5'h00)) |=> !o_busy)
		else $error("homing started outside manual homing mode");

	a_posspeed_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_r.st == ST_IDLE) && i_register_posspeed_select |=> !o_busy)
		else $error("homing started with register position/speed select on");

	a_rear_method_path: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_r.st == ST_FAST) && dog_front && (method == METHOD_REAR) |=> (s_r.st == ST_CREEP) && (s_r.travelled == 32'h0))
		else $error("rear method did not wait for dog rear end");

	a_count_method_path: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_r.st == ST_FAST) && dog_front && (method == METHOD_COUNT) |=> (s_r.st == ST_FINAL) && (s_r.travelled == 32'h0))
		else $error("count method did not count from the front end");

	a_dir_from_cfg: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$rose(o_busy) |-> o_dir == $past(s_r.regs.cfg[CFG_DIR_BIT]))
		else $error("travel direction not taken from the config field");

	a_fast_until_dog: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_r.st == ST_FAST) && !dog_front |=> (s_r.st == ST_FAST))
		else $error("fast phase left without a dog front edge");

	a_front_to_creep: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_r.st == ST_FAST) && dog_front |=> (s_r.st != ST_FAST) && (target_spd == s_r.regs.creep_spd))
		else $error("no switch to creep speed at dog front end");

	a_home_loads_pos: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_done |-> (o_cur_pos == s_r.regs.home_pos) && !o_busy && $past(s_r.st == ST_FINAL))
		else $error("completion without loading the home position value");

	a_start_ignored_busy: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_r.st != ST_IDLE) && i_start |=> (s_r.st != ST_FAST) || $past(s_r.st == ST_FAST))
		else $error("start command restarted a running homing");

	a_start_begins_busy: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_r.st == ST_IDLE) && i_start && mode_ok |=> o_busy && (s_r.st == ST_FAST))
		else $error("accepted start did not begin the fast phase");

	a_busy_state_match: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_busy == (s_r.st != ST_IDLE))
		else $error("busy flag disagrees with the sequencer state");

	a_busy_ends_done: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$fell(o_busy) |-> o_done)
		else $error("busy fell without a completion pulse");

	a_done_one_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_done |=> !o_done)
		else $error("completion pulse longer than one cycle");

	a_idle_no_motion: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_r.st == ST_IDLE) |=> $stable(o_cur_pos))
		else $error("position moved while idle");

	a_speed_zero_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_r.st == ST_IDLE) && $past(s_r.st == ST_IDLE) |=> (o_speed == 16'h0000))
		else $error("speed not zero while idle");

	a_cfg_frozen: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_busy |=> $stable(s_r.regs.cfg))
		else $error("config changed during homing");

	a_dir_held: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_busy && $past(o_busy) |-> $stable(o_dir))
		else $error("direction changed during homing");

	a_fast_target: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_r.st == ST_FAST) |-> (target_spd == s_r.regs.home_spd))
		else $error("fast phase not aimed at homing speed");

	a_creep_target: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		((s_r.st == ST_CREEP) || (s_r.st == ST_FINAL)) |-> (target_spd == s_r.regs.creep_spd))
		else $error("after the dog the target is not creep speed");

	a_pos_follows: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_busy && s_r.tick && (s_r.st != ST_FINAL) |=> (o_cur_pos == (o_dir ? ($past(o_cur_pos) - $past(ramp_spd))
		: ($past(o_cur_pos) + $past(ramp_spd)))))
		else $error("position did not follow the commanded speed");

	a_rear_waits_rear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_r.st == ST_CREEP) && !dog_rear |=> (s_r.st == ST_CREEP))
		else $error("creep phase left without a dog rear edge");

	a_rear_edge_final: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_r.st == ST_CREEP) && dog_rear |=> (s_r.st == ST_FINAL) && (s_r.travelled == 32'h0))
		else $error("distance count not restarted at dog rear end");

	a_final_not_early: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_r.st == ST_FINAL) && !(s_r.tick && (reach >= goal)) |=> (s_r.st == ST_FINAL))
		else $error("homing ended before the distance was covered");

	a_travel_counts: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_r.st == ST_FINAL) && s_r.tick && (reach < goal) |=> (s_r.travelled == $past(s_r.travelled) + $past(ramp_spd)))
		else $error("travelled distance did not add the speed");
endmodule

// ===== dhs_master.sv
// Fieldbus master model: mode selects, start pulse and a position-driven dog
`timescale 1ns/1ps
module dhs_master (
	input wire logic i_ref_clk,
	input wire logic [31:0] i_cur_pos,
	input wire logic [31:0] i_dog_lo,
	input wire logic [31:0] i_dog_hi,
	input wire logic i_low_active,
	input wire logic [2:0] i_mode_fault,
	input wire logic i_start_req,
	output logic o_auto_manual_select,
	output logic [4:0] o_table_select,
	output logic o_register_posspeed_select,
	output logic o_proximity_dog_input,
	output logic o_start
);
	logic in_dog;
	// Mode selects hold steady; only a commanded fault breaks them
	assign o_auto_manual_select = (i_mode_fault != 3'h1);
	assign o_table_select = (i_mode_fault == 3'h2) ? 5'h04 : 5'h00;
	assign o_register_posspeed_select = (i_mode_fault == 3'h3);
	// Dog is a cam over a span of travel, so it follows position, not time
	assign in_dog = ($signed(i_cur_pos) >= $signed(i_dog_lo)) && ($signed(i_cur_pos) <= $signed(i_dog_hi));
	assign o_proximity_dog_input = in_dog ^ i_low_active;
	always_ff @(posedge i_ref_clk) begin
		o_start <= i_start_req;
	end
endmodule

// ===== test_dhs_homing.sv
// Self-checking testbench for the proximity-dog homing sequencer
`timescale 1ns/1ps
module test_dhs_homing;
	import dhs_pkg::*;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [DATA_W-1:0] i_wr_data = '0;
	logic i_wr_en = 1'b0;
	logic i_rd_en = 1'b0;
	logic [DATA_W-1:0] o_rd_data, o_cur_pos;
	logic [SPD_W-1:0] o_speed;
	logic o_dir, o_busy, o_done, ams, psp, dog, start;
	logic [4:0] tsel;
	logic [31:0] dog_lo = 32'h1, dog_hi = 32'h0;
	logic low_act = 1'b0;
	logic [2:0] fault = 3'h0;
	logic start_req = 1'b0;
	int n_fail = 0;
	int checks_done = 0;

	dhs_homing dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
		.i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_auto_manual_select(ams),
		.i_table_select_1(tsel[0]), .i_table_select_2(tsel[1]), .i_table_select_3(tsel[2]),
		.i_table_select_4(tsel[3]), .i_table_select_5(tsel[4]), .i_register_posspeed_select(psp),
		.i_proximity_dog_input(dog), .i_start(start), .o_speed(o_speed), .o_dir(o_dir),
		.o_busy(o_busy), .o_done(o_done), .o_cur_pos(o_cur_pos));
	dhs_master master_u (.i_ref_clk(i_ref_clk), .i_cur_pos(o_cur_pos), .i_dog_lo(dog_lo), .i_dog_hi(dog_hi),
		.i_low_active(low_act), .i_mode_fault(fault), .i_start_req(start_req), .o_auto_manual_select(ams),
		.o_table_select(tsel), .o_register_posspeed_select(psp), .o_proximity_dog_input(dog), .o_start(start));

	initial begin
		forever #20 i_ref_clk = ~i_ref_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wr_data <= d;
		i_wr_en <= 1'b1;
		@(posedge i_ref_clk);
		i_wr_en <= 1'b0;
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd_en <= 1'b1;
		@(posedge i_ref_clk);
		i_rd_en <= 1'b0;
		#1;
		chk(o_rd_data, exp, "read");
	endtask

	// Start under a broken mode or method must leave the axis idle
	task automatic refuse(input logic [2:0] f);
		@(posedge i_ref_clk);
		fault <= f;
		@(posedge i_ref_clk);
		start_req <= 1'b1;
		@(posedge i_ref_clk);
		start_req <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		chk({31'h0, o_busy}, 32'h0, "start refused");
		fault <= 3'h0;
	endtask

	// One homing run; exp is the position just before home is loaded
	task automatic run(input logic [7:0] cfg, input int lo, input int hi, input int exp, input logic [31:0] home,
		input logic [15:0] acc);
		logic [31:0] last, lspd;
		logic pulsed;
		int n, t_full, d;
		wr(OFS_CFG, {24'h0, cfg});
		wr(OFS_ACC, {16'h0, acc});
		wr(OFS_HOME_POS, home);
		dog_lo <= 32'(lo);
		dog_hi <= 32'(hi);
		low_act <= cfg[5];
		start_req <= 1'b1;
		@(posedge i_ref_clk);
		start_req <= 1'b0;
		n = 0;
		t_full = 0;
		pulsed = 1'b0;
		while (o_done !== 1'b1 && n < 20000) begin
			@(posedge i_ref_clk);
			// Drives go out on the edge; the write tries to change config while busy
			i_wr_en <= (n == 2);
			if (n == 2) begin
				i_addr <= OFS_CFG;
				i_wr_data <= 32'h0;
			end
			// A second start as the dog first shows must be ignored by the running sequence
			start_req <= !pulsed && ((dog ^ low_act) === 1'b1);
			if ((dog ^ low_act) === 1'b1) pulsed = 1'b1;
			#1;
			n++;
			if (o_done !== 1'b1) begin
				last = o_cur_pos;
				lspd = {16'h0, o_speed};
			end
			if (t_full == 0 && o_speed === 16'h0014) t_full = n;
			if (n == 3) begin
				chk({31'h0, o_busy}, 32'h1, "busy");
				chk({31'h0, o_dir}, {31'h0, cfg[4]}, "dir");
			end
		end
		d = $signed(last) - exp;
		chk({31'h0, o_done}, 32'h1, "done");
		chk({31'h0, o_busy}, 32'h0, "busy end");
		chk(o_cur_pos, home, "home load");
		chk({31'h0, d <= 30 && d >= -30}, 32'h1, "home distance");
		chk({31'h0, t_full > 500 * (acc + 1) - 50 && t_full < 500 * (acc + 1) + 50}, 32'h1, "ramp");
		if (cfg[3:0] == METHOD_REAR) chk(lspd, 32'h5, "creep");
		rdchk(OFS_CFG, {24'h0, cfg});
		$display("test run cfg %h done", cfg);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		// About two and a half times the expected length of all tests
		#1000000;
		n_fail++;
		close_out();
	end

	initial begin
		repeat (10) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		rdchk(OFS_CFG, 32'h5);
		rdchk(OFS_HOME_SPD, 32'h64);
		rdchk(OFS_CREEP_SPD, 32'hA);
		rdchk(OFS_STATUS, 32'h0);
		rdchk(4'hF, 32'h0);
		wr(OFS_HOME_SPD, 32'h14);
		wr(OFS_CREEP_SPD, 32'h5);
		wr(OFS_POSTDOG, 32'h64);
		wr(OFS_SHIFT, 32'h32);
		rdchk(OFS_POSTDOG, 32'h64);
		$display("test registers done");
		refuse(3'h1);
		refuse(3'h2);
		refuse(3'h3);
		wr(OFS_CFG, 32'h7);
		refuse(3'h0);
		$display("test refusals done");
		run(8'h05, 500, 1000, 1150, 32'h100, 16'h0);
		run(8'h36, -744, -244, -404, 32'hFFFFFF00, 16'h1);
		run(8'h15, -1256, -756, -1410, 32'h1234, 16'h0);
		run(8'h06, 5160, 5660, 5320, 32'h0, 16'h0);
		close_out();
	end
endmodule
